// ==== src/mba_modulo_bitrev.sv ====
// Effective-address correction: circular wrapping and bit-reversed write sequencing
// Summary of operation
// - X circular needs select not 15, bit 15
// - Y circular needs select not 15, bit 14
// - X select 15 disables X read and write wrapping
// - Crossing found by magnitude compare, not equality
// - Write back only for pre/post modify modes
// - Bit reversal only on X-space data writes
// - Modifier is bit-reversed, addresses stay normal
// - Bit reversal needs select, enable, pre/post increment
// - Pivot in modifier bits 14:0, scaled to bytes
// - Byte writes and other modes stay linear
// - Pointer plus pivot, step ignored, LSB clear
// - Bit reversal beats X write wrapping only
// - Reversed index, e.g. 1 to 8, 3 to 12
// - Bounds from start/end registers per space
// - Y circular addresses keep LSB clear
// - Both bounds checked, buffers work both ways
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/10ps
module mba_modulo_bitrev
  import mba_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Avalon-MM register slave
  input  wire logic [4:0]  avsAddress,
  input  wire logic        avsRead,
  input  wire logic        avsWrite,
  input  wire logic [3:0]  avsByteenable,
  input  wire logic [31:0] avsWritedata,
  output logic      [31:0] avsReaddata,
  output logic             avsWaitrequest,
  // Address request from the pipeline
  input  wire logic        agValid,
  input  wire logic [1:0]  agSpace,
  input  wire logic [2:0]  agMode,
  input  wire logic [3:0]  agReg,
  input  wire logic [15:0] agPtr,
  input  wire logic [15:0] agOperand,
  input  wire logic        agByte,
  // Corrected address and pointer write-back
  output logic             eaValid,
  output logic      [15:0] ea,
  output logic             wbValid,
  output logic      [15:0] wbPtr
);

  logic [15:0] modeCtrl;
  logic [15:0] brevMod;
  logic [15:0] xStart;
  logic [15:0] xEnd;
  logic [15:0] yStart;
  logic [15:0] yEnd;
  logic [15:0] lastEa;

  function automatic logic [15:0] rev16(input logic [15:0] v);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 0; i < 16; i++)
      r[i] = v[15-i];
    return r;
  endfunction

  // Reverse-carry add: carries run from MSB toward LSB
  function automatic logic [15:0] revAdd(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = rev16(a) + rev16(b);
    return rev16(s);
  endfunction

  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
      r[7:0] = wd[7:0];
    if (be[1])
      r[15:8] = wd[15:8];
    return r;
  endfunction

  // Bus decode
  wire         busWrite  = avsWrite && !avsWaitrequest;
  wire         wrCtrl    = busWrite && avsAddress == OFS_MODE_CTRL;
  wire         wrBrev    = busWrite && avsAddress == OFS_BREV_MOD;
  wire         wrXs      = busWrite && avsAddress == OFS_X_START;
  wire         wrXe      = busWrite && avsAddress == OFS_X_END;
  wire         wrYs      = busWrite && avsAddress == OFS_Y_START;
  wire         wrYe      = busWrite && avsAddress == OFS_Y_END;
  wire [15:0]  rdSel     = avsAddress == OFS_MODE_CTRL ? modeCtrl :
                           avsAddress == OFS_BREV_MOD  ? brevMod  :
                           avsAddress == OFS_X_START   ? xStart   :
                           avsAddress == OFS_X_END     ? xEnd     :
                           avsAddress == OFS_Y_START   ? yStart   :
                           avsAddress == OFS_Y_END     ? yEnd     :
                           avsAddress == OFS_LAST_EA   ? lastEa   : 16'h0000;
  wire         next_waitrequest = !((avsRead || avsWrite) && avsWaitrequest);
  wire [31:0]  next_readdata    = (avsRead && avsWaitrequest) ? {16'h0000, rdSel} : avsReaddata;

  // Configuration fields
  wire [3:0]   xSel  = modeCtrl[X_SEL_LSB +: 4];
  wire [3:0]   ySel  = modeCtrl[Y_SEL_LSB +: 4];
  wire [3:0]   brSel = modeCtrl[BR_SEL_LSB +: 4];
  wire         circXEn = modeCtrl[X_EN_BIT] && xSel != SEL_NONE;
  wire         circYEn = modeCtrl[Y_EN_BIT] && ySel != SEL_NONE;
  wire         brevEn  = brevMod[BR_EN_BIT] && brSel != SEL_NONE;

  // Mode decode
  wire         modeInc  = agMode == MODE_POST_INC || agMode == MODE_PRE_INC;
  wire         modeDec  = agMode == MODE_POST_DEC || agMode == MODE_PRE_DEC;
  wire         modePre  = agMode == MODE_PRE_INC || agMode == MODE_PRE_DEC;
  wire         modeMod  = modeInc || modeDec;
  wire         spaceY   = agSpace == SPACE_Y;

  wire brevOn = agSpace == SPACE_X_WRITE && !agByte && modeInc &&
                brevEn && agReg == brSel;
  wire circSel = spaceY ? (circYEn && agReg == ySel) : (circXEn && agReg == xSel);
  wire circOn  = circSel && !brevOn;

  // Linear result before any correction
  wire [15:0]  rawSum = modeDec                 ? agPtr - agOperand :
                        modeInc                 ? agPtr + agOperand :
                        agMode == MODE_REG_OFS  ? agPtr + agOperand : agPtr;

  // Circular correction: bounds per space
  wire [15:0]  bStart  = spaceY ? yStart : xStart;
  wire [15:0]  bEnd    = spaceY ? yEnd : xEnd;
  wire         over    = rawSum > bEnd;
  wire         under   = rawSum < bStart;
  wire [15:0]  wrapUp  = bStart + (rawSum - bEnd - 16'h0001);
  wire [15:0]  wrapDn  = bEnd - (bStart - rawSum - 16'h0001);
  wire [15:0]  wrapRaw = over ? wrapUp : under ? wrapDn : rawSum;
  wire [15:0]  wrapVal = spaceY ? {wrapRaw[15:1], 1'b0} : wrapRaw;

  // Bit-reversed step: pivot words scaled to bytes, normal step dropped
  wire [15:0]  pivotBytes = {brevMod[PIVOT_W-1:0], 1'b0};
  wire [15:0]  brevSum    = revAdd(agPtr, pivotBytes);
  wire [15:0]  brevVal    = {brevSum[15:1], 1'b0};

  wire [15:0]  newPtr = brevOn ? brevVal : circOn ? wrapVal : rawSum;
  wire [15:0]  ptrEa  = brevOn ? {agPtr[15:1], 1'b0} :
                        (circOn && spaceY) ? {agPtr[15:1], 1'b0} : agPtr;
  // Register-offset results are corrected but never stored
  wire [15:0]  next_ea  = (modePre || agMode == MODE_REG_OFS) ? newPtr : ptrEa;
  wire         next_wb  = agValid && modeMod;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avsWaitrequest <= 1'b1;
      avsReaddata    <= 32'h0000_0000;
    end
    else
    begin
      avsWaitrequest <= next_waitrequest;
      avsReaddata    <= next_readdata;
    end
  end

  // Software view; defaults leave every correction off
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      modeCtrl <= RST_MODE_CTRL;
      brevMod  <= RST_BREV_MOD;
      xStart   <= RST_BOUND;
      xEnd     <= RST_BOUND;
      yStart   <= RST_BOUND;
      yEnd     <= RST_BOUND;
    end
    else
    begin
      if (wrCtrl)
        modeCtrl <= laneMerge(modeCtrl, avsWritedata, avsByteenable);
      if (wrBrev)
        brevMod <= laneMerge(brevMod, avsWritedata, avsByteenable);
      if (wrXs)
        xStart <= laneMerge(xStart, avsWritedata, avsByteenable);
      if (wrXe)
        xEnd <= laneMerge(xEnd, avsWritedata, avsByteenable);
      if (wrYs)
        yStart <= laneMerge(yStart, avsWritedata, avsByteenable);
      if (wrYe)
        yEnd <= laneMerge(yEnd, avsWritedata, avsByteenable);
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      eaValid <= 1'b0;
      ea      <= 16'h0000;
      wbValid <= 1'b0;
      wbPtr   <= 16'h0000;
      lastEa  <= 16'h0000;
    end
    else
    begin
      eaValid <= agValid;
      wbValid <= next_wb;
      if (agValid)
      begin
        ea     <= next_ea;
        wbPtr  <= newPtr;
        lastEa <= next_ea;
      end
    end
  end

  // Disabled wrapping must leave a post-increment pointer linear
  xCircGate_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && !spaceY && agMode == MODE_POST_INC && !modeCtrl[X_EN_BIT] && !brevOn)
      |=> wbPtr == $past(agPtr) + $past(agOperand))
    else $error("X pointer wrapped while X wrapping is off");
  yCircGate_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && spaceY && agMode == MODE_POST_INC && !modeCtrl[Y_EN_BIT])
      |=> wbPtr == $past(agPtr) + $past(agOperand))
    else $error("Y pointer wrapped while Y wrapping is off");
  xSelNone_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && !spaceY && xSel == SEL_NONE && !brevOn)
      |=> ea == $past(next_ea) && wbPtr == $past(rawSum))
    else $error("X pointer corrected while select is 15");
  regOfsNoWb_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && agMode == MODE_REG_OFS) |=> eaValid && !wbValid)
    else $error("Register offset mode wrote the pointer back");
  brevScope_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && agSpace != SPACE_X_WRITE && agMode == MODE_POST_INC && !circSel)
      |=> wbPtr == $past(agPtr) + $past(agOperand))
    else $error("Bit reversal applied outside X writes");
  brevLsb_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && brevOn) |=> !ea[0] && !wbPtr[0])
    else $error("Bit-reversed address has LSB set");
  yLsbClear_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && spaceY && circOn) |=> !ea[0] && !wbPtr[0])
    else $error("Y circular address has LSB set");
  brevPriority_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && brevOn) |=> wbPtr == $past(brevVal))
    else $error("Wrapping overrode bit reversal");
  wrapInside_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && circOn && modePre && !spaceY && bStart <= bEnd &&
     agPtr >= bStart && agPtr <= bEnd && agOperand <= bEnd - bStart)
      |=> ea >= $past(bStart) && ea <= $past(bEnd))
    else $error("Wrapped address left the buffer");
  resetOff_a: assert property (@(posedge clk) disable iff (!nrst)
    $rose(nrst) |-> !circXEn && !circYEn && !brevEn)
    else $error("Special addressing active after reset");

  // Register bus: exactly one wait state, high again when idle
  busWait_a: assert property (@(posedge clk) disable iff (!nrst)
    ((avsRead || avsWrite) && avsWaitrequest) |=> !avsWaitrequest)
    else $error("Bus request not answered after one wait state");
  busIdle_a: assert property (@(posedge clk) disable iff (!nrst)
    !avsWaitrequest |=> avsWaitrequest)
    else $error("Wait request low for more than one cycle");
  idleWait_a: assert property (@(posedge clk) disable iff (!nrst)
    (!avsRead && !avsWrite) |=> avsWaitrequest)
    else $error("Wait request dropped without a request");
  rdHigh_a: assert property (@(posedge clk) disable iff (!nrst)
    avsReaddata[31:16] == 16'h0000)
    else $error("Read data upper half not zero");

  // Address path: results one cycle after the request
  eaPulse_a: assert property (@(posedge clk) disable iff (!nrst)
    agValid |=> eaValid)
    else $error("Address strobe missing after a request");
  eaQuiet_a: assert property (@(posedge clk) disable iff (!nrst)
    !agValid |=> !eaValid)
    else $error("Address strobe without a request");
  lastEa_a: assert property (@(posedge clk) disable iff (!nrst)
    agValid |=> lastEa == ea)
    else $error("Last address register out of step");
  noModNoWb_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && !modeMod) |=> !wbValid)
    else $error("Unmodified pointer written back");
  wbPulse_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && modeMod) |=> wbValid)
    else $error("Modify mode did not write the pointer back");

  // Bit reversal stays out of the way when not fully enabled
  brevOffCtl_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && agSpace == SPACE_X_WRITE && agMode == MODE_POST_INC && !circSel && !brevEn)
      |=> wbPtr == $past(agPtr) + $past(agOperand))
    else $error("Bit reversal active while not enabled");
  brevLinear_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && agSpace == SPACE_X_WRITE && agByte && agMode == MODE_POST_INC && !circSel)
      |=> wbPtr == $past(agPtr) + $past(agOperand))
    else $error("Byte write took a bit-reversed step");
  brevDecLinear_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && agSpace == SPACE_X_WRITE && agMode == MODE_POST_DEC && !circSel)
      |=> wbPtr == $past(agPtr) - $past(agOperand))
    else $error("Decrementing write took a bit-reversed step");
  brevStep_a: assert property (@(posedge clk) disable iff (!nrst)
    (agValid && brevOn && agMode == MODE_POST_INC) |=> ea == ($past(agPtr) & 16'hFFFE))
    else $error("Post-increment bit-reversed address not the pointer");

endmodule

// ==== src/mba_pkg.sv ====
// Register map, field layout and access codes of the modulo and bit-reverse address logic
package mba_pkg;
  // Register byte offsets on the bus
  localparam logic [4:0]  OFS_MODE_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_BREV_MOD   = 5'h04;
  localparam logic [4:0]  OFS_X_START    = 5'h08;
  localparam logic [4:0]  OFS_X_END      = 5'h0C;
  localparam logic [4:0]  OFS_Y_START    = 5'h10;
  localparam logic [4:0]  OFS_Y_END      = 5'h14;
  localparam logic [4:0]  OFS_LAST_EA    = 5'h18;
  // Reset values
  localparam logic [15:0] RST_MODE_CTRL  = 16'h0FFF;
  localparam logic [15:0] RST_BREV_MOD   = 16'h0000;
  localparam logic [15:0] RST_BOUND      = 16'h0000;
  // Field positions
  localparam int          X_SEL_LSB      = 0;
  localparam int          Y_SEL_LSB      = 4;
  localparam int          BR_SEL_LSB     = 8;
  localparam int          Y_EN_BIT       = 14;
  localparam int          X_EN_BIT       = 15;
  localparam int          BR_EN_BIT      = 15;
  localparam int          PIVOT_W        = 15;
  localparam logic [3:0]  SEL_NONE       = 4'hF;
  // Address space of an access
  localparam logic [1:0]  SPACE_X_READ   = 2'h0;
  localparam logic [1:0]  SPACE_X_WRITE  = 2'h1;
  localparam logic [1:0]  SPACE_Y        = 2'h2;
  // Addressing modes
  localparam logic [2:0]  MODE_INDIRECT  = 3'h0;
  localparam logic [2:0]  MODE_POST_INC  = 3'h1;
  localparam logic [2:0]  MODE_POST_DEC  = 3'h2;
  localparam logic [2:0]  MODE_PRE_INC   = 3'h3;
  localparam logic [2:0]  MODE_PRE_DEC   = 3'h4;
  localparam logic [2:0]  MODE_REG_OFS   = 3'h5;
endpackage

// ==== tb/mba_pipe_model.sv ====
// Pipeline model issuing effective-address requests
`timescale 1ns/10ps
module mba_pipe_model
(
  // Clock
  input  wire logic        clk,
  // Request fields
  output logic             agValid,
  output logic      [1:0]  agSpace,
  output logic      [2:0]  agMode,
  output logic      [3:0]  agReg,
  output logic      [15:0] agPtr,
  output logic      [15:0] agOperand,
  output logic             agByte
);
  initial
  begin
    agValid = 1'b0;
    {agSpace, agMode, agReg, agPtr, agOperand, agByte} = '0;
  end
  // One-cycle request; pointer and operand inverted after so stale values cannot pass
  task automatic req(input logic [1:0] s, input logic [2:0] m, input logic [3:0] r,
                     input logic [15:0] p, input logic [15:0] o, input logic b);
    @(posedge clk);
    agValid <= 1'b1;
    {agSpace, agMode, agReg, agPtr, agOperand, agByte} <= {s, m, r, p, o, b};
    @(posedge clk);
    agValid   <= 1'b0;
    agPtr     <= ~p;
    agOperand <= ~o;
    #1;
  endtask
endmodule

// ==== tb/test_modulo_bitrev_address_gen.sv ====
// Self-checking bench for the modulo and bit-reverse address logic
`timescale 1ns/10ps
module test_modulo_bitrev_address_gen
  import mba_pkg::*;
  ;
  localparam logic [1:0] XR = SPACE_X_READ, XW = SPACE_X_WRITE, YS = SPACE_Y;
  localparam logic [2:0] POI = MODE_POST_INC, POD = MODE_POST_DEC, PRI = MODE_PRE_INC;
  logic        clk, nrst, avsRead, avsWrite, avsWaitrequest, eaValid, wbValid;
  logic        agValid, agByte;
  logic [4:0]  avsAddress;
  logic [31:0] avsWritedata, avsReaddata;
  logic [1:0]  agSpace;
  logic [2:0]  agMode;
  logic [3:0]  agReg;
  logic [15:0] agPtr, agOperand, ea, wbPtr, p, nx;
  int          fail_count, total_checks;

  mba_pipe_model i_pipe (.clk(clk), .agValid(agValid), .agSpace(agSpace), .agMode(agMode),
    .agReg(agReg), .agPtr(agPtr), .agOperand(agOperand), .agByte(agByte));
  mba_modulo_bitrev i_dut (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsByteenable(4'hF),
    .avsWritedata(avsWritedata), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .agValid(agValid), .agSpace(agSpace),
    .agMode(agMode), .agReg(agReg), .agPtr(agPtr), .agOperand(agOperand),
    .agByte(agByte), .eaValid(eaValid), .ea(ea), .wbValid(wbValid), .wbPtr(wbPtr));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    avsWrite     <= 1'b1;
    avsAddress   <= a;
    avsWritedata <= {16'h0000, d};
    @(posedge clk iff !avsWaitrequest);
    avsWrite <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    avsRead    <= 1'b1;
    avsAddress <= a;
    @(posedge clk iff !avsWaitrequest);
    chk(avsReaddata, {16'h0000, e});
    avsRead <= 1'b0;
  endtask
  task automatic ag(input logic [1:0] s, input logic [2:0] m, input logic [3:0] r,
                    input logic [15:0] pt, input logic [15:0] o, input logic b,
                    input logic [15:0] xe, input logic [15:0] xw, input logic xv);
    i_pipe.req(s, m, r, pt, o, b);
    chk({31'h0, eaValid}, 32'h1);
    chk({16'h0000, ea}, {16'h0000, xe});
    chk({31'h0, wbValid}, {31'h0, xv});
    if (xv)
      chk({16'h0000, wbPtr}, {16'h0000, xw});
  endtask
  // Reverse-carry add, worked out independently of the design
  function automatic logic [15:0] rev16(input logic [15:0] v);
    for (int i = 0; i < 16; i++)
      rev16[i] = v[15 - i];
  endfunction
  function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] b);
    return rev16(rev16(a) + rev16(b)) & 16'hFFFE;
  endfunction
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #50000;
    fail_count++;
    wrap_up();
  end
  initial
  begin
    {nrst, avsRead, avsWrite, avsAddress, avsWritedata} = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_MODE_CTRL, 16'h0FFF);
    rd(OFS_BREV_MOD, 16'h0000);
    ag(XR, POI, 4'h3, 16'h1000, 16'h0002, 1'b0, 16'h1000, 16'h1002, 1'b1);
    wr(OFS_X_START, 16'h1000);
    wr(OFS_X_END, 16'h101F);
    wr(OFS_MODE_CTRL, 16'h8FF3);
    ag(XR, POI, 4'h3, 16'h101E, 16'h0004, 1'b0, 16'h101E, 16'h1002, 1'b1);
    ag(XR, POD, 4'h3, 16'h1000, 16'h0002, 1'b0, 16'h1000, 16'h101E, 1'b1);
    ag(XR, MODE_REG_OFS, 4'h3, 16'h101C, 16'h0008, 1'b0, 16'h1004, 16'h0, 1'b0);
    ag(XR, MODE_PRE_DEC, 4'h3, 16'h1000, 16'h0002, 1'b0, 16'h101E, 16'h101E, 1'b1);
    ag(XR, MODE_INDIRECT, 4'h3, 16'h1010, 16'h0005, 1'b0, 16'h1010, 16'h0, 1'b0);
    ag(XW, PRI, 4'h3, 16'h101E, 16'h0002, 1'b0, 16'h1000, 16'h1000, 1'b1);
    ag(XR, POI, 4'h4, 16'h101E, 16'h0004, 1'b0, 16'h101E, 16'h1022, 1'b1);
    rd(OFS_LAST_EA, 16'h101E);
    wr(OFS_LAST_EA, 16'h5555);
    rd(OFS_LAST_EA, 16'h101E);
    wr(5'h1C, 16'hFFFF);
    rd(5'h1C, 16'h0000);
    wr(OFS_MODE_CTRL, 16'h0FF3);
    ag(XR, POI, 4'h3, 16'h101E, 16'h0004, 1'b0, 16'h101E, 16'h1022, 1'b1);
    wr(OFS_MODE_CTRL, 16'h8FFF);
    ag(XW, POI, 4'hF, 16'h101E, 16'h0004, 1'b0, 16'h101E, 16'h1022, 1'b1);
    ag(XR, POI, 4'hF, 16'h101E, 16'h0004, 1'b0, 16'h101E, 16'h1022, 1'b1);
    wr(OFS_Y_START, 16'h2000);
    wr(OFS_Y_END, 16'h203F);
    wr(OFS_MODE_CTRL, 16'h4F5F);
    ag(YS, POI, 4'h5, 16'h203E, 16'h0002, 1'b0, 16'h203E, 16'h2000, 1'b1);
    ag(YS, MODE_REG_OFS, 4'h5, 16'h2010, 16'h0001, 1'b0, 16'h2010, 16'h0, 1'b0);
    wr(OFS_MODE_CTRL, 16'h0F5F);
    ag(YS, POI, 4'h5, 16'h203E, 16'h0002, 1'b0, 16'h203E, 16'h2040, 1'b1);
    wr(OFS_BREV_MOD, 16'h8008);
    wr(OFS_MODE_CTRL, 16'h02FF);
    rd(OFS_BREV_MOD, 16'h8008);
    p = 16'h0100;
    for (int k = 0; k < 16; k++)
    begin
      nx = rev_add(p, 16'h0010);
      ag(XW, POI, 4'h2, p, 16'h0002, 1'b0, p, nx, 1'b1);
      chk({16'h0000, ea}, {24'h000001, 3'h0, k[0], k[1], k[2], k[3], 1'b0});
      p = nx;
    end
    ag(XW, PRI, 4'h2, 16'h0100, 16'h0002, 1'b0, 16'h0110, 16'h0110, 1'b1);
    ag(XR, POI, 4'h2, 16'h0100, 16'h0002, 1'b0, 16'h0100, 16'h0102, 1'b1);
    ag(YS, POI, 4'h2, 16'h0100, 16'h0002, 1'b0, 16'h0100, 16'h0102, 1'b1);
    ag(XW, POI, 4'h2, 16'h0100, 16'h0002, 1'b1, 16'h0100, 16'h0102, 1'b1);
    ag(XW, POD, 4'h2, 16'h0100, 16'h0002, 1'b0, 16'h0100, 16'h00FE, 1'b1);
    wr(OFS_BREV_MOD, 16'h0008);
    ag(XW, POI, 4'h2, 16'h0100, 16'h0002, 1'b0, 16'h0100, 16'h0102, 1'b1);
    wr(OFS_BREV_MOD, 16'h8008);
    wr(OFS_MODE_CTRL, 16'h0FFF);
    ag(XW, POI, 4'h2, 16'h0100, 16'h0002, 1'b0, 16'h0100, 16'h0102, 1'b1);
    wr(OFS_X_START, 16'h0100);
    wr(OFS_X_END, 16'h010F);
    wr(OFS_MODE_CTRL, 16'h82F2);
    ag(XW, POI, 4'h2, 16'h010E, 16'h0002, 1'b0, 16'h010E, 16'h011E, 1'b1);
    ag(XR, POI, 4'h2, 16'h010E, 16'h0002, 1'b0, 16'h010E, 16'h0100, 1'b1);
    // Second reset in mid-run must drop every special mode again
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rd(OFS_MODE_CTRL, 16'h0FFF);
    rd(OFS_BREV_MOD, 16'h0000);
    ag(XW, POI, 4'h2, 16'h010E, 16'h0002, 1'b0, 16'h010E, 16'h0110, 1'b1);
    wrap_up();
  end
endmodule
